// ### amp_misc_pkg.sv
// amp_misc_pkg: offsets, field positions, reset values and codes shared by
// the miscellaneous control and status register bank.
// assumes a byte-wide register port with 8-bit offsets.
package amp_misc_pkg;

    // register offsets on the control port
    localparam logic [7:0] OFF_PIN_FUNCTION_SELECT = 8'h61;
    localparam logic [7:0] OFF_PROCESSING_BYPASS_CTRL = 8'h66;
    localparam logic [7:0] OFF_SILICON_IDENTITY = 8'h67;
    localparam logic [7:0] OFF_OPERATING_STATE_REPORT = 8'h68;
    localparam logic [7:0] OFF_AUTO_MUTE_STATUS = 8'h69;
    localparam logic [7:0] OFF_CARRIER_PHASE_CTRL = 8'h6a;

    // reset values
    localparam logic [7:0] RST_PIN_FUNCTION_SELECT = 8'h00;
    localparam logic [7:0] RST_PROCESSING_BYPASS_CTRL = 8'h00;
    localparam logic [7:0] RST_OPERATING_STATE_REPORT = 8'h00;
    localparam logic [7:0] RST_AUTO_MUTE_STATUS = 8'h00;
    localparam logic [7:0] RST_CARRIER_PHASE_CTRL = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // identity byte value; arbitrary
    localparam logic [7:0] SILICON_IDENTITY_BYTE = 8'h5a;

    // writable field masks
    localparam logic [7:0] MASK_PIN_FUNCTION = 8'h1f;
    localparam logic [7:0] MASK_BYPASS = 8'hff;
    localparam logic [7:0] MASK_PHASE = 8'hff;

    // field positions
    localparam int PIN_SEL_HI = 4;
    localparam int BYP_UNIQUE_COEF = 3;
    localparam int BYP_FIR = 2;
    localparam int BYP_DRC = 1;
    localparam int BYP_EQ = 0;
    localparam int MUTE_RIGHT_BIT = 1;
    localparam int MUTE_LEFT_BIT = 0;
    localparam int PHASE_SEL_HI = 3;
    localparam int PHASE_SEL_LO = 2;
    localparam int I2S_SYNC_BIT = 1;
    localparam int RAMP_SYNC_BIT = 0;

    // multi-purpose pin function codes
    typedef enum logic [4:0] {
        PIN_OFF_LOW = 5'b00000,
        PIN_MUTE_BOTH = 5'b00011,
        PIN_MUTE_LEFT = 5'b00100,
        PIN_MUTE_RIGHT = 5'b00101,
        PIN_CLOCK_INVALID = 5'b00110,
        PIN_FAULT_LOW = 5'b01011
    } pin_function_t;

    // operating state codes
    typedef enum logic [7:0] {
        ST_DEEP_SLEEP = 8'h00,
        ST_SLEEP = 8'h01,
        ST_HIGH_IMPEDANCE = 8'h02,
        ST_PLAYBACK = 8'h03
    } operating_state_code_t;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // processing chain controls
    typedef struct packed {
        logic unique_coef;
        logic fir_bypass;
        logic dynamic_range_compressor_bypass;
        logic eq_bypass;
    } bypass_ctrl_t;

    // carrier phase controls
    typedef struct packed {
        logic [1:0] ramp_phase;
        logic i2s_sync_en;
        logic ramp_sync_en;
    } phase_ctrl_t;

endpackage

// ### amp_ctrl_reg.sv
// amp_ctrl_reg: one writable byte register with a mask of implemented bits.
// assumes write strobe and address decode are done by the parent.
`timescale 1ns/100ps
module amp_ctrl_reg
    import amp_misc_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hff
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_we,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_value
);
    logic [7:0] value;
    logic [7:0] next_value;

    // masked write; unimplemented bits stay zero
    always_comb begin
        next_value = value;
        if (i_we) begin
            next_value = i_wdata & WRITE_MASK;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            value <= RESET_VALUE;
        end else begin
            value <= next_value;
        end
    end

    assign o_value = value;
endmodule

// ### amp_pin_mux.sv
// amp_pin_mux: picks the level driven onto the multi-purpose pin.
// assumes all flag inputs are synchronous to the core clock.
`timescale 1ns/100ps
module amp_pin_mux
    import amp_misc_pkg::*;
(
    input wire logic [4:0] i_select,
    input wire logic i_left_auto_mute_status,
    input wire logic i_right_auto_mute_status,
    input wire logic i_clock_error,
    input wire logic i_clock_missing,
    input wire logic i_fault,
    output logic o_level
);
    // decode of the pin function; reserved codes hold the pin low
    always_comb begin
        o_level = 1'b0;
        case (i_select)
            PIN_OFF_LOW: o_level = 1'b0;
            PIN_MUTE_BOTH: begin
                o_level = i_left_auto_mute_status
                    & i_right_auto_mute_status;
            end
            PIN_MUTE_LEFT: o_level = i_left_auto_mute_status;
            PIN_MUTE_RIGHT: o_level = i_right_auto_mute_status;
            PIN_CLOCK_INVALID: begin
                o_level = i_clock_error | i_clock_missing;
            end
            PIN_FAULT_LOW: o_level = ~i_fault;
            default: o_level = 1'b0;
        endcase
    end
endmodule

// ### amp_misc_control_status_regs.sv
// amp_misc_control_status_regs: pin function, processing bypass, identity,
// operating state, auto-mute status and carrier phase registers.
// assumes a synchronous byte register port from the control interface and
// status inputs synchronous to the core clock.
`timescale 1ns/100ps

// Summary of operation
// - select 00000 holds pin low; 00011 asserts when both channels muted
// - select 00100 drives left mute flag; 00101 drives right mute flag
// - select 00110 drives clock invalid: clock error or clock missing
// - select 01011 makes the pin the active-low fault output
// - bypass bit 3 set gives separate coefficients; clear shares left ones
// - bypass bit 2 set routes audio around the 128-tap FIR
// - bypass bit 1 set bypasses the compressor in left/right paths only
// - bypass bit 0 set bypasses the equalizers in left/right paths only
// - read-only state byte: 0 deep sleep, 1 sleep, 2 hi-z, 3 play
// - read-only bit 1 shows right channel auto-mute status
// - read-only bit 0 shows left channel auto-mute status
// - bits 3-2 of phase control pick one of four ramp phases
// - phase control bit 1 enables PWM alignment to audio framing
// - phase control bit 0 enables ramp carrier phase sync
module amp_misc_control_status_regs
    import amp_misc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic [1:0] i_operating_state_code,
    input wire logic i_left_auto_mute_status,
    input wire logic i_right_auto_mute_status,
    input wire logic i_clock_error,
    input wire logic i_clock_missing,
    input wire logic i_fault,
    input wire logic i_play_active,
    output logic o_multi_pin,
    output logic o_multi_pin_oe,
    output logic o_unique_coef,
    output logic o_fir_bypass,
    output logic o_dynamic_range_compressor_bypass,
    output logic o_eq_bypass,
    output logic [1:0] o_ramp_phase,
    output logic o_i2s_sync_en,
    output logic o_ramp_sync_en
);
    reg_req_t req;
    logic [7:0] pin_sel_q;
    logic [7:0] bypass_q;
    logic [7:0] phase_q;
    logic [7:0] state_q;
    logic [7:0] mute_q;
    logic [7:0] next_state;
    logic [7:0] next_mute;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic pin_level;
    logic pin_level_q;
    logic next_pin_level;
    logic phase_we;
    bypass_ctrl_t bypass;
    phase_ctrl_t phase;

    assign req = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr,
                   wdata: i_reg_wdata};

    // writable control registers
    amp_ctrl_reg #(
        .RESET_VALUE(RST_PIN_FUNCTION_SELECT),
        .WRITE_MASK(MASK_PIN_FUNCTION)
    ) u_pin_sel (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_we(req.wr && req.addr == OFF_PIN_FUNCTION_SELECT),
        .i_wdata(req.wdata),
        .o_value(pin_sel_q)
    );

    amp_ctrl_reg #(
        .RESET_VALUE(RST_PROCESSING_BYPASS_CTRL),
        .WRITE_MASK(MASK_BYPASS)
    ) u_bypass (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_we(req.wr && req.addr == OFF_PROCESSING_BYPASS_CTRL),
        .i_wdata(req.wdata),
        .o_value(bypass_q)
    );

    // phase takes writes at any time; the host orders it before playback
    assign phase_we = req.wr && req.addr == OFF_CARRIER_PHASE_CTRL;

    amp_ctrl_reg #(
        .RESET_VALUE(RST_CARRIER_PHASE_CTRL),
        .WRITE_MASK(MASK_PHASE)
    ) u_phase (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_we(phase_we),
        .i_wdata(req.wdata),
        .o_value(phase_q)
    );

    // status capture; bus writes never reach these
    always_comb begin
        next_state = {6'h00, i_operating_state_code};
        next_mute = ZERO_BYTE;
        next_mute[MUTE_RIGHT_BIT] = i_right_auto_mute_status;
        next_mute[MUTE_LEFT_BIT] = i_left_auto_mute_status;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= RST_OPERATING_STATE_REPORT;
            mute_q <= RST_AUTO_MUTE_STATUS;
        end else begin
            state_q <= next_state;
            mute_q <= next_mute;
        end
    end

    // read decode; unmapped offsets read zero
    always_comb begin
        next_rvalid = req.rd;
        next_rdata = rdata;
        if (req.rd) begin
            case (req.addr)
                OFF_PIN_FUNCTION_SELECT: next_rdata = pin_sel_q;
                OFF_PROCESSING_BYPASS_CTRL: next_rdata = bypass_q;
                OFF_SILICON_IDENTITY: next_rdata = SILICON_IDENTITY_BYTE;
                OFF_OPERATING_STATE_REPORT: next_rdata = state_q;
                OFF_AUTO_MUTE_STATUS: next_rdata = mute_q;
                OFF_CARRIER_PHASE_CTRL: next_rdata = phase_q;
                default: next_rdata = ZERO_BYTE;
            endcase
        end
    end

    // read data and pin level registers
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata <= ZERO_BYTE;
            rvalid <= 1'b0;
            pin_level_q <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            pin_level_q <= next_pin_level;
        end
    end

    // multi-purpose pin function select
    amp_pin_mux u_pin_mux (
        .i_select(pin_sel_q[PIN_SEL_HI:0]),
        .i_left_auto_mute_status(i_left_auto_mute_status),
        .i_right_auto_mute_status(i_right_auto_mute_status),
        .i_clock_error(i_clock_error),
        .i_clock_missing(i_clock_missing),
        .i_fault(i_fault),
        .o_level(pin_level)
    );

    assign next_pin_level = pin_level;

    // processing chain and carrier phase controls
    always_comb begin
        bypass.unique_coef = bypass_q[BYP_UNIQUE_COEF];
        bypass.fir_bypass = bypass_q[BYP_FIR];
        bypass.dynamic_range_compressor_bypass = bypass_q[BYP_DRC];
        bypass.eq_bypass = bypass_q[BYP_EQ];
        phase.ramp_phase = phase_q[PHASE_SEL_HI:PHASE_SEL_LO];
        phase.i2s_sync_en = phase_q[I2S_SYNC_BIT];
        phase.ramp_sync_en = phase_q[RAMP_SYNC_BIT];
    end

    assign o_reg_rdata = rdata;
    assign o_reg_rvalid = rvalid;
    assign o_multi_pin = pin_level_q;
    assign o_multi_pin_oe = 1'b1; // pin is always an output here
    assign o_unique_coef = bypass.unique_coef;
    assign o_fir_bypass = bypass.fir_bypass;
    assign o_dynamic_range_compressor_bypass =
        bypass.dynamic_range_compressor_bypass;
    assign o_eq_bypass = bypass.eq_bypass;
    assign o_ramp_phase = phase.ramp_phase;
    assign o_i2s_sync_en = phase.i2s_sync_en;
    assign o_ramp_sync_en = phase.ramp_sync_en;
endmodule

// ### amp_misc_checker.sv
// amp_misc_checker: port-level properties of the register bank
// assumes it is bound to amp_misc_control_status_regs on one clock
`timescale 1ns/100ps
module amp_misc_checker
    import amp_misc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [1:0] i_operating_state_code,
    input wire logic i_left_auto_mute_status,
    input wire logic i_right_auto_mute_status,
    input wire logic i_clock_error,
    input wire logic i_clock_missing,
    input wire logic i_fault,
    input wire logic o_multi_pin,
    input wire logic o_unique_coef,
    input wire logic o_fir_bypass,
    input wire logic o_dynamic_range_compressor_bypass,
    input wire logic o_eq_bypass,
    input wire logic [1:0] o_ramp_phase,
    input wire logic o_i2s_sync_en,
    input wire logic o_ramp_sync_en
);
    logic [4:0] sel;
    wire l = i_left_auto_mute_status;
    wire r = i_right_auto_mute_status;
    wire wa = i_reg_wr;
    wire ra = i_reg_rd;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // shadow of the pin function selection
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sel <= 5'h00;
        end else if (wa && i_reg_addr == OFF_PIN_FUNCTION_SELECT) begin
            sel <= i_reg_wdata[4:0];
        end
    end
    AST_PIN_OFF: assert property (sel == 5'h00 |=> !o_multi_pin)
        else $error("pin not low when off");
    AST_PIN_BOTH: assert property (
        sel == 5'h03 |=> o_multi_pin == $past(l && r))
        else $error("pin not both-muted flag");
    AST_PIN_LEFT: assert property (
        sel == 5'h04 |=> o_multi_pin == $past(l))
        else $error("pin not left mute flag");
    AST_PIN_RIGHT: assert property (
        sel == 5'h05 |=> o_multi_pin == $past(r))
        else $error("pin not right mute flag");
    AST_PIN_CLOCK: assert property (
        sel == 5'h06
        |=> o_multi_pin == $past(i_clock_error || i_clock_missing))
        else $error("pin not clock invalid flag");
    AST_PIN_FAULT: assert property (
        sel == 5'h0b |=> o_multi_pin != $past(i_fault))
        else $error("pin not active-low fault");
    AST_BYPASS: assert property (
        wa && i_reg_addr == OFF_PROCESSING_BYPASS_CTRL
        |=> {o_unique_coef, o_fir_bypass, o_dynamic_range_compressor_bypass,
        o_eq_bypass} == $past(i_reg_wdata[3:0]))
        else $error("bypass outputs differ from write");
    AST_PHASE: assert property (
        wa && i_reg_addr == OFF_CARRIER_PHASE_CTRL
        |=> {o_ramp_phase, o_i2s_sync_en, o_ramp_sync_en}
        == $past(i_reg_wdata[3:0]))
        else $error("phase outputs differ from write");
    AST_STATE_RD: assert property (
        ra && i_reg_addr == OFF_OPERATING_STATE_REPORT
        |=> o_reg_rdata == {6'h00, $past(i_operating_state_code, 2)})
        else $error("state read wrong");
    AST_MUTE_RD: assert property (
        ra && i_reg_addr == OFF_AUTO_MUTE_STATUS
        |=> o_reg_rdata == {6'h00, $past(r, 2), $past(l, 2)})
        else $error("mute status read wrong");
    AST_ID_RD: assert property (
        ra && i_reg_addr == OFF_SILICON_IDENTITY
        |=> o_reg_rdata == SILICON_IDENTITY_BYTE)
        else $error("identity read wrong");
endmodule

bind amp_misc_control_status_regs amp_misc_checker amp_misc_checker_inst (.*);

// ### amp_misc_control_status_regs_tb_top.sv
// testbench: random and corner register traffic, pin and status checks
// assumes the package and the bound checker are compiled first
`timescale 1ns/100ps
module amp_misc_control_status_regs_tb_top;
    import amp_misc_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic wr = 1'b0, rd = 1'b0, l = 1'b0, r = 1'b0, err = 1'b0;
    logic miss = 1'b0, flt = 1'b0, play = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, a, v;
    logic [1:0] st = 2'h0, phase;
    logic [4:0] s;
    logic rvalid, pin, oe, uc, fir, dynamic_range_compressor, eq, i2s, rsync;
    logic [7:0] offs[7] = '{8'h61, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h62};
    logic [7:0] rst[7] = '{8'h00, 8'h00, SILICON_IDENTITY_BYTE, 8'h00,
        8'h00, 8'h00, 8'h00};
    logic [7:0] rw[3] = '{8'h61, 8'h66, 8'h6a};
    logic [4:0] codes[7] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0b, 5'h07};
    int mismatches = 0, total_checks = 0, cycles = 0;

    // 40 MHz core clock
    always #12.5 i_core_clk = ~i_core_clk;

    amp_misc_control_status_regs amp_misc_control_status_regs_inst (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_operating_state_code(st), .i_left_auto_mute_status(l),
        .i_right_auto_mute_status(r), .i_clock_error(err),
        .i_clock_missing(miss), .i_fault(flt), .i_play_active(play),
        .o_multi_pin(pin), .o_multi_pin_oe(oe), .o_unique_coef(uc),
        .o_fir_bypass(fir), .o_dynamic_range_compressor_bypass(dynamic_range_compressor),
        .o_eq_bypass(eq), .o_ramp_phase(phase), .o_i2s_sync_en(i2s),
        .o_ramp_sync_en(rsync)
    );

    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr_reg(input logic [7:0] ad, input logic [7:0] val);
        @(negedge i_core_clk);
        wr = 1'b1;
        addr = ad;
        wdata = val;
        @(negedge i_core_clk);
        wr = 1'b0;
    endtask

    // one-cycle read strobe, data taken while rvalid stands
    task automatic rd_reg(input logic [7:0] ad, output logic [7:0] val);
        @(negedge i_core_clk);
        rd = 1'b1;
        addr = ad;
        @(negedge i_core_clk);
        rd = 1'b0;
        chk({7'h00, rvalid}, 8'h01);
        val = rdata;
    endtask

    // expected pin level for a selection and the present inputs
    function automatic logic pin_exp(input logic [4:0] sl);
        case (sl)
            5'h03: pin_exp = l & r;
            5'h04: pin_exp = l;
            5'h05: pin_exp = r;
            5'h06: pin_exp = err | miss;
            5'h0b: pin_exp = ~flt;
            default: pin_exp = 1'b0;
        endcase
    endfunction

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'h9ea0));
        repeat (6) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_arst_n = 1'b1;
        // reset values, unmapped offset, ignored read-only writes
        for (int i = 0; i < 7; i++) begin
            rd_reg(offs[i], d);
            chk(d, rst[i]);
        end
        for (int i = 2; i < 5; i++) begin
            wr_reg(offs[i], 8'($urandom));
            rd_reg(offs[i], d);
            chk(d, rst[i]);
        end
        // writable registers: every phase code first, then random;
        // phase is programmed while playback stays idle, single device
        for (int i = 0; i < 60; i++) begin
            a = rw[i % 3];
            v = (i < 12) ? {4'h0, 2'(i / 3), 2'(i)} : 8'($urandom);
            wr_reg(a, v);
            rd_reg(a, d);
            chk(d, (a == 8'h61) ? (v & MASK_PIN_FUNCTION) : v);
            if (a == OFF_PROCESSING_BYPASS_CTRL)
                chk({4'h0, uc, fir, dynamic_range_compressor, eq}, {4'h0, v[3:0]});
            if (a == OFF_CARRIER_PHASE_CTRL)
                chk({4'h0, phase, i2s, rsync}, {4'h0, v[3:0]});
        end
        // mid-run reset brings every register back to its reset value
        @(negedge i_core_clk);
        i_arst_n = 1'b0;
        repeat (2) @(negedge i_core_clk);
        i_arst_n = 1'b1;
        chk({uc, fir, dynamic_range_compressor, eq, phase, i2s, rsync}, 8'h00);
        chk({7'h00, pin}, 8'h00);
        for (int i = 0; i < 7; i++) begin
            rd_reg(offs[i], d);
            chk(d, rst[i]);
        end
        // every pin code against random status inputs
        for (int i = 0; i < 70; i++) begin
            s = codes[i % 7];
            wr_reg(OFF_PIN_FUNCTION_SELECT, {3'h7, s});
            {st, l, r, err, miss, flt, play} = 8'($urandom);
            repeat (2) @(negedge i_core_clk);
            chk({7'h00, pin}, {7'h00, pin_exp(s)});
            chk({7'h00, oe}, 8'h01);
            rd_reg(OFF_OPERATING_STATE_REPORT, d);
            chk(d, {6'h00, st});
            rd_reg(OFF_AUTO_MUTE_STATUS, d);
            chk(d, {6'h00, r, l});
        end
        test_done();
    end
endmodule
